/* rtl/expander_pkg.sv */
// Shared offsets, field positions and counts for the expander port block
package expander_pkg;
  localparam int PORT_W = 8;
  localparam int PINS_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_PORT = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_LATCH = 4'ha;
  localparam logic [PORT_W-1:0] RST_PULLUP = 8'h00;
  localparam logic [PORT_W-1:0] RST_FLAGS = 8'h00;
  localparam logic [PORT_W-1:0] RST_CAPTURE = 8'h00;
  localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
  localparam logic [PORT_W-1:0] RD_UNMAPPED = 8'h00;
  // Serial clock falling edges counted after the read strobe before the one on which the LSb leaves
  localparam logic [2:0] LSB_OUT_EDGE = 3'h7;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic PORT_FIRST = 1'b0;
  localparam logic PORT_SECOND = 1'b1;
endpackage : expander_pkg

/* rtl/io_port_slice.sv */
// One 8-bit port: pull-ups, output latch, change detect, flags, capture
`timescale 1ns/1ps
module io_port_slice (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [expander_pkg::PORT_W-1:0] pinLvl,
  input wire logic [expander_pkg::PORT_W-1:0] isInput,
  input wire logic [expander_pkg::PORT_W-1:0] irqEn,
  input wire logic [expander_pkg::PORT_W-1:0] srcDefault,
  input wire logic [expander_pkg::PORT_W-1:0] compare_default_reg,
  input wire logic wrPullup,
  input wire logic wrLatch,
  input wire logic [expander_pkg::PORT_W-1:0] wrData,
  input wire logic clrIrq,
  output logic [expander_pkg::PORT_W-1:0] pullupBits_r,
  output logic [expander_pkg::PORT_W-1:0] latchBits_r,
  output logic [expander_pkg::PORT_W-1:0] flagBits_r,
  output logic [expander_pkg::PORT_W-1:0] captureBits_r,
  output logic irqPend_r
);
  import expander_pkg::*;

  logic [PORT_W-1:0] refLvl_r;
  logic refLoaded_r;
  logic [PORT_W-1:0] mismatch;

  // Only enabled input pins are compared at all
  assign mismatch = isInput & irqEn &
    ((srcDefault & (pinLvl ^ compare_default_reg)) |
     (~srcDefault & (pinLvl ^ refLvl_r)));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pullupBits_r <= RST_PULLUP;
    end else if (wrPullup) begin
      pullupBits_r <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latchBits_r <= RST_LATCH;
    end else if (wrLatch) begin
      latchBits_r <= wrData;
    end
  end

  // Reset cannot load a port value, so the baseline is taken after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refLoaded_r <= 1'b0;
    end else begin
      refLoaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refLvl_r <= RST_CAPTURE;
    end else if (!refLoaded_r) begin
      refLvl_r <= pinLvl;
    end else if (clrIrq || (!irqPend_r && |mismatch)) begin
      refLvl_r <= pinLvl;
    end
  end

  // A pending mismatch at clear time re-raises at once: set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqPend_r <= 1'b0;
      flagBits_r <= RST_FLAGS;
      captureBits_r <= RST_CAPTURE;
    end else if (refLoaded_r && (!irqPend_r || clrIrq) && |mismatch) begin
      irqPend_r <= 1'b1;
      flagBits_r <= mismatch;
      captureBits_r <= pinLvl;
    end else if (clrIrq) begin
      irqPend_r <= 1'b0;
      flagBits_r <= RST_FLAGS;
    end
  end
endmodule : io_port_slice

/* rtl/io_expander_port_irq.sv */
// Port data path and interrupt-on-change logic of a 16-bit I/O expander
// Function
// - Pull-up on for set bit, input pin
// - Flags mark causing enabled pins; writes ignored
// - Disabled pins never set their flag
// - Capture loads pins on interrupt, held
// - Port read gives pins, write hits latch
// - Latch read gives latch; latch drives outputs
// - Per-pin enable and per-pin compare source
// - Each port own interrupt, cleared by read
// - Merge 0 separate, merge 1 ORed
// - Merged outputs clear after both ports read
// - Pin-change mode compares against previous value
// - Default mode compares against default bit
// - Outputs active-low, active-high or open-drain
// - Only enabled input pins cause interrupts
// - Interrupt holds until read; writes ignored
// - Clear only after LSb shifted out
// - Only first event loads capture
// - Pending change reasserts at once on clear
// - Clearing refreshes pin-change baseline
// - Default mismatch persists despite reads
// - Merge control is configuration bit 6
// - Bit 2 open-drain overrides polarity
// - Bit 1 polarity: 1 high, 0 low
`timescale 1ns/1ps
module io_expander_port_irq (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serClk,
  input wire logic [expander_pkg::ADDR_W-1:0] regAddr,
  input wire logic regPortSel,
  input wire logic regWrEn,
  input wire logic [expander_pkg::PORT_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [expander_pkg::PORT_W-1:0] regRdData_r,
  input wire logic [expander_pkg::PINS_W-1:0] dirInput,
  input wire logic [expander_pkg::PINS_W-1:0] changeIrqEnable,
  input wire logic [expander_pkg::PINS_W-1:0] irqSourceDefault,
  input wire logic [expander_pkg::PINS_W-1:0] compareDefault,
  input wire logic irqMirror,
  input wire logic irqOpenDrain,
  input wire logic irqOutputPolarity,
  input wire logic [expander_pkg::PINS_W-1:0] pinIn,
  output logic [expander_pkg::PINS_W-1:0] pinOut_r,
  output logic [expander_pkg::PINS_W-1:0] pinOe_r,
  output logic [expander_pkg::PINS_W-1:0] pullupOn_r,
  output logic irqOutFirst_r,
  output logic irqOutFirstOe_r,
  output logic irqOutSecond_r,
  output logic irqOutSecondOe_r
);
  import expander_pkg::*;

  logic [PINS_W-1:0] pinMeta_r;
  logic [PINS_W-1:0] pinLvl_r;
  logic serMeta_r;
  logic serSync_r;
  logic serPrev_r;
  logic serFall;
  logic [1:0] clrArm_r;
  logic [2:0] bitCnt_r;
  logic [1:0] clrPulse;
  logic clrRead;
  logic [1:0] wrPullup;
  logic [1:0] wrLatch;
  logic [PINS_W-1:0] pullupBits;
  logic [PINS_W-1:0] latchBits;
  logic [PINS_W-1:0] flagBits;
  logic [PINS_W-1:0] captureBits;
  logic [1:0] irqPend;
  logic [1:0] irqActive;
  logic [PORT_W-1:0] rdSel;

  // Pins and the serial clock come from outside this clock domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= '0;
      pinLvl_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinLvl_r <= pinMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serMeta_r <= 1'b0;
      serSync_r <= 1'b0;
      serPrev_r <= 1'b0;
    end else begin
      serMeta_r <= serClk;
      serSync_r <= serMeta_r;
      serPrev_r <= serSync_r;
    end
  end

  assign serFall = serPrev_r && !serSync_r;

  assign clrRead = regRdEn &&
    (regAddr == ADDR_CAPTURE || regAddr == ADDR_PORT);

  // Clear is armed by the read and fired once the byte has been shifted out
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clrArm_r <= 2'b00;
      bitCnt_r <= CNT_ZERO;
    end else if (clrRead) begin
      clrArm_r <= regPortSel ? 2'b10 : 2'b01;
      bitCnt_r <= CNT_ZERO;
    end else if (serFall && |clrArm_r) begin
      bitCnt_r <= bitCnt_r + CNT_ONE;
      if (bitCnt_r == LSB_OUT_EDGE) begin
        clrArm_r <= 2'b00;
      end
    end
  end

  assign clrPulse = (serFall && !clrRead && bitCnt_r == LSB_OUT_EDGE) ?
    clrArm_r : 2'b00;

  // Port and latch writes both land in the latch; flag/capture writes drop
  assign wrLatch[0] = regWrEn && regPortSel == PORT_FIRST &&
    (regAddr == ADDR_PORT || regAddr == ADDR_LATCH);
  assign wrLatch[1] = regWrEn && regPortSel == PORT_SECOND &&
    (regAddr == ADDR_PORT || regAddr == ADDR_LATCH);
  assign wrPullup[0] = regWrEn && regPortSel == PORT_FIRST &&
    regAddr == ADDR_PULLUP;
  assign wrPullup[1] = regWrEn && regPortSel == PORT_SECOND &&
    regAddr == ADDR_PULLUP;

  for (genvar p = 0; p < 2; p++) begin : g_port
    io_port_slice u_slice (
      .clk(clk),
      .rstn(rstn),
      .pinLvl(pinLvl_r[p*PORT_W +: PORT_W]),
      .isInput(dirInput[p*PORT_W +: PORT_W]),
      .irqEn(changeIrqEnable[p*PORT_W +: PORT_W]),
      .srcDefault(irqSourceDefault[p*PORT_W +: PORT_W]),
      .compare_default_reg(compareDefault[p*PORT_W +: PORT_W]),
      .wrPullup(wrPullup[p]),
      .wrLatch(wrLatch[p]),
      .wrData(regWrData),
      .clrIrq(clrPulse[p]),
      .pullupBits_r(pullupBits[p*PORT_W +: PORT_W]),
      .latchBits_r(latchBits[p*PORT_W +: PORT_W]),
      .flagBits_r(flagBits[p*PORT_W +: PORT_W]),
      .captureBits_r(captureBits[p*PORT_W +: PORT_W]),
      .irqPend_r(irqPend[p])
    );
  end

  always_comb begin
    unique case (regAddr)
      ADDR_PULLUP: rdSel = regPortSel ? pullupBits[15:8] : pullupBits[7:0];
      ADDR_FLAGS: rdSel = regPortSel ? flagBits[15:8] : flagBits[7:0];
      ADDR_CAPTURE:
        rdSel = regPortSel ? captureBits[15:8] : captureBits[7:0];
      ADDR_PORT: rdSel = regPortSel ? pinLvl_r[15:8] : pinLvl_r[7:0];
      ADDR_LATCH: rdSel = regPortSel ? latchBits[15:8] : latchBits[7:0];
      default: rdSel = RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_r <= RD_UNMAPPED;
    end else if (regRdEn) begin
      regRdData_r <= rdSel;
    end
  end

  // Pull-ups only on inputs; latches drive only output pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinOut_r <= '0;
      pinOe_r <= '0;
      pullupOn_r <= '0;
    end else begin
      pinOut_r <= latchBits;
      pinOe_r <= ~dirInput;
      pullupOn_r <= pullupBits & dirInput;
    end
  end

  // Merged mode ORs the two ports, so every pending port must be read before it drops
  assign irqActive[0] = irqMirror ? |irqPend : irqPend[0];
  assign irqActive[1] = irqMirror ? |irqPend : irqPend[1];

  // Open drain only ever pulls low and releases otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqOutFirst_r <= 1'b0;
      irqOutFirstOe_r <= 1'b0;
      irqOutSecond_r <= 1'b0;
      irqOutSecondOe_r <= 1'b0;
    end else if (irqOpenDrain) begin
      irqOutFirst_r <= 1'b0;
      irqOutFirstOe_r <= irqActive[0];
      irqOutSecond_r <= 1'b0;
      irqOutSecondOe_r <= irqActive[1];
    end else begin
      irqOutFirst_r <= irqOutputPolarity ? irqActive[0] : !irqActive[0];
      irqOutFirstOe_r <= 1'b1;
      irqOutSecond_r <= irqOutputPolarity ? irqActive[1] : !irqActive[1];
      irqOutSecondOe_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  pullup_gate_a: assert property (
    ##1 pullupOn_r == $past(pullupBits & dirInput))
    else $error("pull-up enabled on output or cleared bit");

  flag_enable_a: assert property (
    $rose(irqPend[0]) |->
      (flagBits[7:0] & ~$past(changeIrqEnable[7:0] & dirInput[7:0])) == '0)
    else $error("flag set for pin without interrupt enable");

  capture_hold_a: assert property (
    irqPend[0] && !clrPulse[0] |=> $stable(captureBits[7:0]))
    else $error("capture changed while interrupt pending");

  latch_write_a: assert property (
    wrLatch[0] |=> latchBits[7:0] == $past(regWrData))
    else $error("port or latch write did not reach latch");

  port_read_a: assert property (
    regRdEn && regAddr == ADDR_PORT && regPortSel == PORT_FIRST |=>
      regRdData_r == $past(pinLvl_r[7:0]))
    else $error("port read did not return pin levels");

  irq_hold_a: assert property (
    irqPend[0] && !clrPulse[0] |=> irqPend[0])
    else $error("interrupt dropped without a completed read");

  clear_after_lsb_a: assert property (
    $fell(irqPend[0]) |-> $past(clrPulse[0]))
    else $error("interrupt cleared before LSb left");

  // Registered outputs lag reset release by one edge, hence the rstn terms
  mirror_or_a: assert property (
    rstn && irqMirror && !irqOpenDrain |=>
      irqOutFirst_r == ($past(|irqPend) ~^ $past(irqOutputPolarity)) &&
      irqOutSecond_r == irqOutFirst_r)
    else $error("merged outputs do not follow ORed interrupts");

  od_drive_a: assert property (
    irqOpenDrain |=> !irqOutFirst_r && !irqOutSecond_r)
    else $error("open-drain output driven high");

  separate_out_a: assert property (
    rstn && !irqMirror && !irqOpenDrain |=>
      irqOutSecond_r == ($past(irqPend[1]) ~^ $past(irqOutputPolarity)))
    else $error("separate second output does not follow its port");

  merged_hold_a: assert property (
    rstn && irqMirror && !irqOpenDrain && irqPend[1] |=>
      irqOutFirst_r == $past(irqOutputPolarity))
    else $error("merged first output dropped while second pending");

  drive_enable_a: assert property (
    rstn && !irqOpenDrain |=>
      irqOutFirstOe_r && irqOutSecondOe_r)
    else $error("driven interrupt output not enabled");

  od_release_a: assert property (
    rstn && irqOpenDrain |=>
      irqOutFirstOe_r == $past(irqActive[0]))
    else $error("open-drain enable does not follow interrupt");

  flag_change_a: assert property (
    $changed(flagBits[7:0]) |->
      $past(clrPulse[0] || !irqPend[0]))
    else $error("flags changed outside raise or clear");

  capture_load_a: assert property (
    $rose(irqPend[0]) |->
      captureBits[7:0] == $past(pinLvl_r[7:0]))
    else $error("capture missed the pin levels at interrupt");

  second_clear_a: assert property (
    $fell(irqPend[1]) |-> $past(clrPulse[1]))
    else $error("second port interrupt cleared without its read");

  input_only_a: assert property (
    $rose(irqPend[1]) |->
      (flagBits[15:8] & ~$past(changeIrqEnable[15:8] & dirInput[15:8])) == '0)
    else $error("second port flag set for disabled or output pin");

  flag_hold_a: assert property (
    irqPend[0] && !clrPulse[0] |=> $stable(flagBits[7:0]))
    else $error("flags changed while interrupt pending");

  default_cause_a: assert property (
    $rose(irqPend[0]) |-> (flagBits[7:0] & $past(irqSourceDefault[7:0] &
      ~(pinLvl_r[7:0] ^ compareDefault[7:0]))) == '0)
    else $error("default-mode flag set for pin matching its default");

  irq_raise_c: cover property ($rose(irqPend[0]));
  clear_done_c: cover property (clrPulse[0] ##1 !irqPend[0]);
  reassert_c: cover property (clrPulse[1] ##1 irqPend[1]);
  merged_both_c: cover property (irqMirror && irqPend == 2'b11);
  default_hold_c: cover property (clrPulse[0] && irqSourceDefault[0] ##1 irqPend[0]);
endmodule : io_expander_port_irq

/* tb/host_model.sv */
// Host stand-in: register strobes and a framed link clock
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic serClk,
  output logic [expander_pkg::ADDR_W-1:0] regAddr,
  output logic regPortSel,
  output logic regWrEn,
  output logic [expander_pkg::PORT_W-1:0] regWrData,
  output logic regRdEn
);
  import expander_pkg::*;
  initial begin
    serClk = 1'b0;
    regAddr = 4'h0;
    regPortSel = 1'b0;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic p, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regPortSel <= p;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    // Released data shows a changed value, never the stale byte
    regWrData <= ~d;
  endtask : wr
  // Link clock rests low between frames; 200 ns period inside
  task automatic rd(input logic p, input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regPortSel <= p;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    repeat (16) begin
      repeat (4) @(posedge clk);
      serClk <= ~serClk;
    end
    repeat (8) @(posedge clk);
  endtask : rd
endmodule : host_model

/* tb/test_io_expander_port_irq.sv */
// Self-checking bench for the expander port and interrupt block
`timescale 1ns/1ps
module test_io_expander_port_irq;
  import expander_pkg::*;
  logic clk, rstn, serClk, regPortSel, regWrEn, regRdEn;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData_r;
  logic [15:0] dirInput, changeIrqEnable, irqSourceDefault;
  logic [15:0] compareDefault, pinIn, pinOut_r, pinOe_r, pullupOn_r;
  logic irqMirror, irqOpenDrain, irqOutputPolarity;
  logic irqOutFirst_r, irqOutFirstOe_r, irqOutSecond_r, irqOutSecondOe_r;
  int err_count = 0;
  int num_checks = 0;
  int seed, i;
  logic [31:0] d;
  host_model host_u (.clk(clk), .serClk(serClk), .regAddr(regAddr),
    .regPortSel(regPortSel), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn));
  io_expander_port_irq dut_u (.clk(clk), .rstn(rstn), .serClk(serClk),
    .regAddr(regAddr), .regPortSel(regPortSel), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_r(regRdData_r),
    .dirInput(dirInput), .changeIrqEnable(changeIrqEnable),
    .irqSourceDefault(irqSourceDefault), .compareDefault(compareDefault),
    .irqMirror(irqMirror), .irqOpenDrain(irqOpenDrain),
    .irqOutputPolarity(irqOutputPolarity), .pinIn(pinIn),
    .pinOut_r(pinOut_r), .pinOe_r(pinOe_r), .pullupOn_r(pullupOn_r),
    .irqOutFirst_r(irqOutFirst_r), .irqOutFirstOe_r(irqOutFirstOe_r),
    .irqOutSecond_r(irqOutSecond_r), .irqOutSecondOe_r(irqOutSecondOe_r));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic p, input logic [3:0] a,
                       input logic [7:0] e);
    host_u.rd(p, a);
    chk({8'h00, regRdData_r}, {8'h00, e});
  endtask : rdchk
  // Pin level and enable expected for an interrupt line
  function automatic logic [1:0] pinOf(input logic act);
    if (irqOpenDrain) begin
      return {1'b0, act};
    end
    return {act ^ ~irqOutputPolarity, 1'b1};
  endfunction : pinOf
  task automatic irqChk(input logic a, input logic b);
    chk({12'h000, irqOutFirst_r, irqOutFirstOe_r, irqOutSecond_r,
      irqOutSecondOe_r}, {12'h000, pinOf(a), pinOf(b)});
  endtask : irqChk
  // Pins change once, then settle past the synchroniser
  task automatic setPins(input logic [15:0] v);
    @(posedge clk);
    pinIn <= v;
    repeat (10) @(posedge clk);
  endtask : setPins
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    seed = 44870;
    rstn = 1'b0;
    dirInput = 16'hffff;
    changeIrqEnable = 16'h0000;
    irqSourceDefault = 16'h0000;
    compareDefault = 16'h0000;
    irqMirror = 1'b0;
    irqOpenDrain = 1'b0;
    irqOutputPolarity = 1'b0;
    pinIn = 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    irqChk(1'b0, 1'b0);
    for (i = 6; i <= 10; i++) begin
      rdchk(1'b0, i[3:0], 8'h00);
    end
    rdchk(1'b1, 4'h3, RD_UNMAPPED);
    $display("reset test done");
    repeat (4) begin
      d = $random(seed);
      dirInput <= d[31:16];
      host_u.wr(PORT_FIRST, ADDR_PULLUP, d[7:0]);
      host_u.wr(PORT_SECOND, ADDR_PORT, d[15:8]);
      host_u.wr(PORT_FIRST, ADDR_FLAGS, d[23:16]);
      rdchk(PORT_FIRST, ADDR_PULLUP, d[7:0]);
      chk(pullupOn_r, {8'h00, d[7:0]} & d[31:16]);
      rdchk(PORT_SECOND, ADDR_LATCH, d[15:8]);
      chk(pinOut_r, {d[15:8], 8'h00});
      chk(pinOe_r, ~d[31:16]);
      rdchk(PORT_FIRST, ADDR_FLAGS, 8'h00);
      setPins(d[15:0] ^ d[31:16]);
      rdchk(PORT_SECOND, ADDR_PORT, pinIn[15:8]);
      setPins(16'h0000);
    end
    // Port reads refresh the change baseline; settle it at zero before use
    rdchk(PORT_SECOND, ADDR_PORT, 8'h00);
    $display("register test done");
    dirInput <= 16'hfffd;
    changeIrqEnable <= 16'h0103;
    setPins(16'h0002);
    irqChk(1'b0, 1'b0);
    setPins(16'h0006);
    irqChk(1'b0, 1'b0);
    setPins(16'h0007);
    irqChk(1'b1, 1'b0);
    host_u.wr(PORT_FIRST, ADDR_CAPTURE, 8'hff);
    host_u.wr(PORT_FIRST, ADDR_PORT, 8'h00);
    irqChk(1'b1, 1'b0);
    setPins(16'h0006);
    rdchk(PORT_FIRST, ADDR_FLAGS, 8'h01);
    rdchk(PORT_FIRST, ADDR_CAPTURE, 8'h07);
    irqChk(1'b1, 1'b0);
    rdchk(PORT_FIRST, ADDR_CAPTURE, 8'h06);
    irqChk(1'b0, 1'b0);
    $display("pin change test done");
    irqSourceDefault <= 16'h0001;
    compareDefault <= 16'h0001;
    repeat (10) @(posedge clk);
    irqChk(1'b1, 1'b0);
    rdchk(PORT_FIRST, ADDR_FLAGS, 8'h01);
    rdchk(PORT_FIRST, ADDR_CAPTURE, 8'h06);
    irqChk(1'b1, 1'b0);
    compareDefault <= 16'h0000;
    rdchk(PORT_FIRST, ADDR_PORT, 8'h06);
    irqChk(1'b0, 1'b0);
    irqSourceDefault <= 16'h0000;
    $display("default test done");
    irqMirror <= 1'b1;
    setPins(16'h0107);
    irqChk(1'b1, 1'b1);
    rdchk(PORT_FIRST, ADDR_CAPTURE, 8'h07);
    irqChk(1'b1, 1'b1);
    rdchk(PORT_SECOND, ADDR_CAPTURE, 8'h01);
    irqChk(1'b0, 1'b0);
    irqMirror <= 1'b0;
    setPins(16'h0007);
    irqChk(1'b0, 1'b1);
    rdchk(PORT_SECOND, ADDR_PORT, 8'h00);
    irqChk(1'b0, 1'b0);
    $display("mirror test done");
    for (i = 0; i < 4; i++) begin
      {irqOpenDrain, irqOutputPolarity} <= i[1:0];
      repeat (4) @(posedge clk);
      irqChk(1'b0, 1'b0);
      setPins(pinIn ^ 16'h0001);
      irqChk(1'b1, 1'b0);
      rdchk(PORT_FIRST, ADDR_PORT, pinIn[7:0]);
      irqChk(1'b0, 1'b0);
    end
    $display("output mode test done");
    conclude();
  end
endmodule : test_io_expander_port_irq
